// ==== include/uapc_pkg.sv ====
// package: register map, field positions and shared types
package uapc_pkg;
    // ******************************
    // register byte offsets
    // ******************************
    localparam logic [7:0] FN_ADDR_OFF = 8'h00;
    localparam logic [7:0] PWR_OFF = 8'h04;
    localparam logic [7:0] DEV_CTRL_OFF = 8'h08;
    localparam logic [7:0] INTR_OFF = 8'h0c;
    localparam logic [7:0] LINKST_OFF = 8'h10;
    // ******************************
    // power register fields
    // ******************************
    localparam int PWR_ISO = 7;
    localparam int PWR_SOFT = 6;
    localparam int PWR_HS_ENABLE = 5;
    localparam int PWR_HSACT = 4;
    localparam int PWR_RST = 3;
    localparam int PWR_RESUME = 2;
    localparam int PWR_SUSP = 1;
    localparam int PWR_SUSPOE = 0;
    localparam logic [7:0] PWR_RESET_VAL = 8'h20;
    // ******************************
    // common interrupt fields
    // ******************************
    localparam int INT_SOF = 3;
    localparam int INT_RESET = 2;
    localparam int INT_RESUME = 1;
    localparam int INT_SUSPEND = 0;
    localparam int DEV_CTRL_HOST = 2;
    localparam logic [7:0] ZERO8 = 8'h00;

    // token seen on the bus, or token to be issued
    typedef struct packed {
        logic valid;
        logic [1:0] kind;
        logic iso;
        logic [6:0] addr;
    } uapc_token_s;

    typedef enum logic [1:0] {
        TK_OUT = 2'b00,
        TK_IN = 2'b01,
        TK_SOF = 2'b10,
        TK_SETUP = 2'b11
    } uapc_tok_e;

    // line events reported by the transceiver logic
    typedef struct packed {
        logic bus_reset;
        logic resume_seen;
        logic suspend_seen;
        logic hs_ok;
    } uapc_line_s;

    typedef enum logic [1:0] {
        ISO_IDLE = 2'b00,
        ISO_WAIT = 2'b01,
        ISO_SEND = 2'b10
    } uapc_iso_e;
endpackage : uapc_pkg

// ==== verilog/uapc_iso_gate.sv ====
// iso frame-wait gate for a packet marked ready
`timescale 1ns/1ps
`default_nettype none
module uapc_iso_gate (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic enable_i,
    input wire logic pkt_ready_i,
    input wire logic tok_hit_i,
    input wire logic [1:0] tok_kind_i,
    // result
    output logic send_data_o,
    output logic send_zlp_o
);
    uapc_pkg::uapc_iso_e st_q;

    // ******************************
    // frame wait state
    // ******************************
    // hold until frame start
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_q <= uapc_pkg::ISO_IDLE;
        end else begin
            case (st_q)
                uapc_pkg::ISO_IDLE: begin
                    if (pkt_ready_i && enable_i) begin
                        st_q <= uapc_pkg::ISO_WAIT;
                    end else if (pkt_ready_i) begin
                        st_q <= uapc_pkg::ISO_SEND;
                    end
                end
                uapc_pkg::ISO_WAIT: begin
                    if (tok_hit_i && tok_kind_i == uapc_pkg::TK_SOF) begin
                        st_q <= uapc_pkg::ISO_SEND;
                    end
                end
                uapc_pkg::ISO_SEND: begin
                    if (tok_hit_i && tok_kind_i == uapc_pkg::TK_IN) begin
                        st_q <= uapc_pkg::ISO_IDLE;
                    end
                end
                default: st_q <= uapc_pkg::ISO_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            send_data_o <= 1'b0;
            send_zlp_o <= 1'b0;
        end else begin
            send_data_o <= tok_hit_i && tok_kind_i == uapc_pkg::TK_IN
                && st_q == uapc_pkg::ISO_SEND;
            send_zlp_o <= tok_hit_i && tok_kind_i == uapc_pkg::TK_IN
                && st_q == uapc_pkg::ISO_WAIT;
        end
    end
endmodule : uapc_iso_gate
`default_nettype wire

// ==== verilog/uapc_top.sv ====
// address and power control with apb register access
`timescale 1ns/1ps
`default_nettype none
module uapc_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // token stream from the packet decoder
    input wire uapc_pkg::uapc_token_s rx_tok_i,
    input wire logic tx_pkt_ready_i,
    output logic tok_accept_o,
    output logic iso_send_data_o,
    output logic iso_send_zlp_o,
    // host token issue
    input wire logic [1:0] host_tok_kind_i,
    output uapc_pkg::uapc_token_s host_tok_o,
    // transceiver line events, from the pin domain
    input wire uapc_pkg::uapc_line_s line_i,
    // transceiver controls
    output logic dp_dm_oe_o,
    output logic hs_allow_o,
    output logic drive_reset_o,
    output logic drive_resume_o,
    output logic host_mode_o,
    output logic suspend_pin_o,
    output logic suspend_pin_oe_o
);
    logic [6:0] fn_addr_q;
    logic [7:0] pwr_q;
    logic host_q;
    logic [3:0] intr_q;
    uapc_pkg::uapc_line_s l_s1_q;
    uapc_pkg::uapc_line_s l_s2_q;
    uapc_pkg::uapc_line_s l_s3_q;
    logic wr_en;
    logic rd_en;
    logic intr_rd;
    logic hit;
    logic rise_rst;
    logic rise_res;
    logic rise_sus;

    // ******************************
    // pin synchronisers
    // ******************************
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            l_s1_q <= '0;
            l_s2_q <= '0;
            l_s3_q <= '0;
        end else begin
            l_s1_q <= line_i;
            l_s2_q <= l_s1_q;
            l_s3_q <= l_s2_q;
        end
    end
    // edges are taken after the second stage only
    assign rise_rst = l_s2_q.bus_reset && !l_s3_q.bus_reset;
    assign rise_res = l_s2_q.resume_seen && !l_s3_q.resume_seen;
    assign rise_sus = l_s2_q.suspend_seen && !l_s3_q.suspend_seen;

    // ******************************
    // apb decode
    // ******************************
    // zero wait states; unmapped offsets read zero with pslverr
    assign pready_o = 1'b1;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && penable_i && !pwrite_i;
    assign intr_rd = rd_en && paddr_i == uapc_pkg::INTR_OFF;
    always_comb begin
        case (paddr_i)
            uapc_pkg::FN_ADDR_OFF, uapc_pkg::PWR_OFF, uapc_pkg::DEV_CTRL_OFF,
            uapc_pkg::INTR_OFF, uapc_pkg::LINKST_OFF: pslverr_o = 1'b0;
            default: pslverr_o = psel_i && penable_i;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                uapc_pkg::FN_ADDR_OFF: prdata_o <= {25'h000_0000, fn_addr_q};
                uapc_pkg::PWR_OFF: prdata_o <= {24'h00_0000, pwr_q};
                uapc_pkg::DEV_CTRL_OFF: prdata_o <= {29'h0, host_q, 2'b00};
                uapc_pkg::INTR_OFF: prdata_o <= {28'h000_0000, intr_q};
                uapc_pkg::LINKST_OFF: prdata_o <= {28'h000_0000, l_s2_q};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ******************************
    // function address and role
    // ******************************
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fn_addr_q <= 7'h00;
        end else if (wr_en && paddr_i == uapc_pkg::FN_ADDR_OFF) begin
            fn_addr_q <= pwdata_i[6:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            host_q <= 1'b0;
        end else if (wr_en && paddr_i == uapc_pkg::DEV_CTRL_OFF) begin
            host_q <= pwdata_i[uapc_pkg::DEV_CTRL_HOST];
        end
    end
    assign host_mode_o = host_q;

    assign hit = rx_tok_i.valid && !host_q &&
        (rx_tok_i.addr == fn_addr_q || rx_tok_i.kind == uapc_pkg::TK_SOF);
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tok_accept_o <= 1'b0;
        end else begin
            tok_accept_o <= hit;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            host_tok_o <= '0;
        end else begin
            host_tok_o.valid <= host_q;
            host_tok_o.kind <= host_tok_kind_i;
            host_tok_o.iso <= 1'b0;
            host_tok_o.addr <= fn_addr_q;
        end
    end

    // ******************************
    // iso frame wait
    // ******************************
    // gate instance
    uapc_iso_gate u_iso (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(pwr_q[uapc_pkg::PWR_ISO] && !host_q),
        .pkt_ready_i(tx_pkt_ready_i && rx_tok_i.iso),
        .tok_hit_i(hit),
        .tok_kind_i(rx_tok_i.kind),
        .send_data_o(iso_send_data_o),
        .send_zlp_o(iso_send_zlp_o)
    );

    // ******************************
    // power register; iso, soft, hs enable and suspend oe share one process, other fields one each
    // ******************************
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pwr_q[7:5] <= uapc_pkg::PWR_RESET_VAL[7:5];
            pwr_q[0] <= uapc_pkg::PWR_RESET_VAL[0];
        end else if (wr_en && paddr_i == uapc_pkg::PWR_OFF) begin
            pwr_q[7:5] <= pwdata_i[7:5];
            pwr_q[0] <= pwdata_i[0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pwr_q[uapc_pkg::PWR_HSACT] <= 1'b0;
        end else if (l_s2_q.hs_ok && pwr_q[uapc_pkg::PWR_HS_ENABLE]) begin
            pwr_q[uapc_pkg::PWR_HSACT] <= 1'b1;
        end else if (!pwr_q[uapc_pkg::PWR_HS_ENABLE]) begin
            pwr_q[uapc_pkg::PWR_HSACT] <= 1'b0;
        end
    end

    // reset: host writes, peripheral mirrors bus
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pwr_q[uapc_pkg::PWR_RST] <= 1'b0;
        end else if (host_q) begin
            if (wr_en && paddr_i == uapc_pkg::PWR_OFF) begin
                pwr_q[uapc_pkg::PWR_RST] <= pwdata_i[uapc_pkg::PWR_RST];
            end
        end else begin
            pwr_q[uapc_pkg::PWR_RST] <= l_s2_q.bus_reset;
        end
    end

    // host self-sets resume; set wins over write
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pwr_q[uapc_pkg::PWR_RESUME] <= 1'b0;
        end else if (host_q && rise_res && pwr_q[uapc_pkg::PWR_SUSP]) begin
            pwr_q[uapc_pkg::PWR_RESUME] <= 1'b1;
        end else if (wr_en && paddr_i == uapc_pkg::PWR_OFF) begin
            pwr_q[uapc_pkg::PWR_RESUME] <= pwdata_i[uapc_pkg::PWR_RESUME];
        end
    end

    // peripheral set on suspend, cleared by read or resume
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pwr_q[uapc_pkg::PWR_SUSP] <= 1'b0;
        end else if (host_q) begin
            if (wr_en && paddr_i == uapc_pkg::PWR_OFF) begin
                pwr_q[uapc_pkg::PWR_SUSP] <= pwdata_i[uapc_pkg::PWR_SUSP];
            end
        end else if (rise_sus) begin
            pwr_q[uapc_pkg::PWR_SUSP] <= 1'b1;
        end else if (intr_rd || pwr_q[uapc_pkg::PWR_RESUME]) begin
            pwr_q[uapc_pkg::PWR_SUSP] <= 1'b0;
        end
    end

    // ******************************
    // common interrupt flags
    // ******************************
    // read clears; a same-cycle event still sets
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            intr_q <= 4'h0;
        end else begin
            intr_q <= (intr_rd ? 4'h0 : intr_q) | {
                hit && rx_tok_i.kind == uapc_pkg::TK_SOF,
                rise_rst, rise_res && pwr_q[uapc_pkg::PWR_SUSP],
                rise_sus && !host_q};
        end
    end

    // ******************************
    // transceiver controls
    // ******************************
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dp_dm_oe_o <= 1'b0;
            hs_allow_o <= 1'b1;
            drive_reset_o <= 1'b0;
            drive_resume_o <= 1'b0;
            suspend_pin_o <= 1'b0;
            suspend_pin_oe_o <= 1'b0;
        end else begin
            dp_dm_oe_o <= host_q || pwr_q[uapc_pkg::PWR_SOFT];
            hs_allow_o <= pwr_q[uapc_pkg::PWR_HS_ENABLE];
            drive_reset_o <= host_q && pwr_q[uapc_pkg::PWR_RST];
            // resume while suspended; software ends it
            drive_resume_o <= pwr_q[uapc_pkg::PWR_RESUME]
                && (pwr_q[uapc_pkg::PWR_SUSP] || drive_resume_o);
            suspend_pin_o <= pwr_q[uapc_pkg::PWR_SUSP];
            suspend_pin_oe_o <= pwr_q[uapc_pkg::PWR_SUSPOE];
        end
    end

    // ******************************
    // checks
    // ******************************
    AST_ADDR_MATCH: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        tok_accept_o |-> $past(rx_tok_i.addr) == $past(fn_addr_q)
        || $past(rx_tok_i.kind) == uapc_pkg::TK_SOF)
        else $error("token accepted with wrong address");
    AST_ROLE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_en && paddr_i == uapc_pkg::DEV_CTRL_OFF
        |=> host_q == $past(pwdata_i[uapc_pkg::DEV_CTRL_HOST]))
        else $error("role bit not taken");
    AST_HOST_ADDR: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        host_q |=> host_tok_o.addr == $past(fn_addr_q))
        else $error("host token address wrong");
    AST_SOFT: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !host_q && !pwr_q[6] ##1 !host_q |-> !dp_dm_oe_o)
        else $error("drivers on while detached");
    AST_HS_ENABLE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !pwr_q[5] |=> !hs_allow_o && !pwr_q[4])
        else $error("hs allowed while disabled");
    AST_HSACT: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        l_s2_q.hs_ok && pwr_q[5] |=> pwr_q[4])
        else $error("hs active not set");
    AST_RESET: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !host_q ##1 !host_q |-> pwr_q[3] == $past(l_s2_q.bus_reset))
        else $error("reset bit not tracking bus");
    AST_RESUME: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        drive_resume_o |-> $past(pwr_q[2]))
        else $error("resume driven without bit");
    AST_SELF_RES: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        host_q && rise_res && pwr_q[1] |=> pwr_q[2])
        else $error("host resume not self set");
    AST_SUSP_CLR: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !host_q && intr_rd && !rise_sus |=> !pwr_q[1])
        else $error("suspend not cleared by read");
    AST_SUSP_PIN: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        suspend_pin_oe_o |-> $past(pwr_q[0]))
        else $error("suspend pin driven without enable");
    AST_INTR_CLR: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        intr_rd && !rise_rst && !rise_res && !rise_sus && !hit
        |=> intr_q == 4'h0)
        else $error("flags survive read");
endmodule : uapc_top
`default_nettype wire

// ==== tb/uapc_bus_model.sv ====
// usb bus partner model: tokens and line events toward the block
`timescale 1ns/1ps
`default_nettype none
module uapc_bus_model (
    // clock
    input wire logic sys_clk_i,
    // bus side
    output var uapc_pkg::uapc_token_s tok_o,
    output var uapc_pkg::uapc_line_s line_o
);
    initial begin
        tok_o = '0;
        line_o = '0;
    end
    // ************************
    // token and line drivers
    // ************************
    // idle fields flip so a stale address never looks current
    task automatic send_tok(input logic [1:0] k, input logic iso,
                            input logic [6:0] a);
        @(posedge sys_clk_i);
        tok_o <= {1'b1, k, iso, a};
        @(posedge sys_clk_i);
        tok_o <= {1'b0, ~k, ~iso, ~a};
    endtask : send_tok
    task automatic set_line(input logic [3:0] v);
        @(posedge sys_clk_i);
        line_o <= v;
    endtask : set_line
endmodule : uapc_bus_model
`default_nettype wire

// ==== tb/uapc_top_tb_top.sv ====
// self-checking bench for the address and power control block
`timescale 1ns/1ps
`default_nettype none
module uapc_top_tb_top;
    logic clk, rst_n, psel, pen, pwr, pkt_rdy, probe, tok_q;
    logic pready, pslverr, acc, sdat, szlp;
    logic dp, hs, drst, dres, hmode, sp, spoe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] hkind;
    logic [6:0] fa, fb;
    uapc_pkg::uapc_token_s rx_tok, htok;
    uapc_pkg::uapc_line_s line;
    int err_count, n_compared, cyc;
    logic [32:0] rd_q[$];
    logic [2:0] tk_q[$];
    logic [17:0] pn_q[$];

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    uapc_top DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .rx_tok_i(rx_tok), .tx_pkt_ready_i(pkt_rdy),
        .tok_accept_o(acc), .iso_send_data_o(sdat), .iso_send_zlp_o(szlp),
        .host_tok_kind_i(hkind), .host_tok_o(htok), .line_i(line),
        .dp_dm_oe_o(dp), .hs_allow_o(hs), .drive_reset_o(drst),
        .drive_resume_o(dres), .host_mode_o(hmode), .suspend_pin_o(sp),
        .suspend_pin_oe_o(spoe));

    uapc_bus_model PM (.sys_clk_i(clk), .tok_o(rx_tok), .line_o(line));

    // ************************
    // checking
    // ************************
    task automatic report(input string w, input logic [32:0] e, s);
        err_count++;
        $display("unexpected %s expected %h seen %h", w, e, s);
    endtask : report
    task automatic cmp_rd(input logic [32:0] s);
        logic [32:0] e;
        e = rd_q.size() ? rd_q.pop_front() : 'x;
        n_compared++;
        if (s !== e) report("read", e, s);
    endtask : cmp_rd
    task automatic cmp_tk(input logic [2:0] s);
        logic [2:0] e;
        e = tk_q.size() ? tk_q.pop_front() : 'x;
        n_compared++;
        if (s !== e) report("token result", {30'h0, e}, {30'h0, s});
    endtask : cmp_tk
    task automatic cmp_pn(input logic [17:0] s);
        logic [17:0] e;
        e = pn_q.size() ? pn_q.pop_front() : 'x;
        n_compared++;
        if (s !== e) report("pins", {15'h0000, e}, {15'h0000, s});
    endtask : cmp_pn
    task automatic complete_run;
        // notes never matched by a result count as mismatches
        err_count += rd_q.size() + tk_q.size() + pn_q.size();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run

    // watcher: takes the oldest note whenever a result shows
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1 && !pwr) cmp_rd({pslverr, prdata});
        if (tok_q) cmp_tk({acc, sdat, szlp});
        if (probe) cmp_pn({dp, hs, drst, dres, hmode, sp, spoe, htok.valid,
                           htok.kind, htok.iso, htok.addr});
        tok_q <= rx_tok.valid;
        cyc <= cyc + 1;
        if (cyc > 8000) begin
            err_count++;
            complete_run;
        end
    end

    // ************************
    // drivers
    // ************************
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // only the bench timeout ends a wait for pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic se = 1'b0);
        rd_q.push_back({se, 24'h00_0000, e});
        apb(1'b0, a, $urandom);
    endtask : rd
    task automatic tk(input logic [1:0] k, input logic iso,
                      input logic [6:0] a, input logic [2:0] e);
        tk_q.push_back(e);
        PM.send_tok(k, iso, a);
    endtask : tk
    task automatic pn(input logic [7:0] v);
        hkind <= 2'($urandom);
        repeat (3) @(posedge clk);
        pn_q.push_back({v, hkind, 1'b0, fa});
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
    endtask : pn
    // line events need three edges to reach the registers
    task automatic ln(input logic [3:0] v);
        PM.set_line(v);
        repeat (4) @(posedge clk);
    endtask : ln

    // ************************
    // main sequence
    // ************************
    initial begin
        {rst_n, psel, pen, pwr, pkt_rdy, probe, tok_q} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        hkind = uapc_pkg::TK_IN;
        fa = 7'h00;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        void'($urandom(32'hb768));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(uapc_pkg::PWR_OFF, uapc_pkg::PWR_RESET_VAL);
        rd(uapc_pkg::FN_ADDR_OFF, 8'h00);
        rd(uapc_pkg::DEV_CTRL_OFF, 8'h00);
        rd(uapc_pkg::INTR_OFF, 8'h00);
        pn(8'h40);
        rd(8'h14, 8'h00, 1'b1);
        apb(1'b1, 8'h14, $urandom);
        fa = 7'($urandom);
        fb = fa ^ (7'($urandom) | 7'h01);
        apb(1'b1, uapc_pkg::FN_ADDR_OFF, {25'($urandom), fa});
        rd(uapc_pkg::FN_ADDR_OFF, {1'b0, fa});
        tk(uapc_pkg::TK_OUT, 1'b0, fa, 3'b100);
        tk(uapc_pkg::TK_OUT, 1'b0, fb, 3'b000);
        tk(uapc_pkg::TK_SETUP, 1'b0, fa, 3'b100);
        tk(uapc_pkg::TK_SETUP, 1'b0, fb, 3'b000);
        tk(uapc_pkg::TK_SOF, 1'b0, fb, 3'b100);
        rd(uapc_pkg::INTR_OFF, 8'h08);
        rd(uapc_pkg::INTR_OFF, 8'h00);
        wr(uapc_pkg::PWR_OFF, 8'hff);
        rd(uapc_pkg::PWR_OFF, 8'he5);
        pn(8'hc2);
        wr(uapc_pkg::PWR_OFF, 8'h00);
        pn(8'h00);
        wr(uapc_pkg::PWR_OFF, 8'h80);
        @(posedge clk);
        pkt_rdy <= 1'b1;
        @(posedge clk);
        pkt_rdy <= 1'b0;
        tk(uapc_pkg::TK_IN, 1'b1, fa, 3'b101);
        tk(uapc_pkg::TK_SOF, 1'b0, fa, 3'b100);
        tk(uapc_pkg::TK_IN, 1'b1, fa, 3'b110);
        rd(uapc_pkg::INTR_OFF, 8'h08);
        wr(uapc_pkg::PWR_OFF, 8'h01);
        ln(4'b0010);
        rd(uapc_pkg::PWR_OFF, 8'h03);
        pn(8'h06);
        rd(uapc_pkg::INTR_OFF, 8'h01);
        rd(uapc_pkg::PWR_OFF, 8'h01);
        ln(4'b0000);
        ln(4'b0010);
        wr(uapc_pkg::PWR_OFF, 8'h05);
        pn(8'h12);
        rd(uapc_pkg::PWR_OFF, 8'h05);
        wr(uapc_pkg::PWR_OFF, 8'h01);
        pn(8'h02);
        rd(uapc_pkg::INTR_OFF, 8'h01);
        ln(4'b0000);
        wr(uapc_pkg::PWR_OFF, 8'h20);
        ln(4'b1001);
        rd(uapc_pkg::LINKST_OFF, 8'h09);
        rd(uapc_pkg::PWR_OFF, 8'h38);
        rd(uapc_pkg::INTR_OFF, 8'h04);
        ln(4'b0000);
        rd(uapc_pkg::PWR_OFF, 8'h30);
        wr(uapc_pkg::PWR_OFF, 8'h00);
        rd(uapc_pkg::PWR_OFF, 8'h00);
        wr(uapc_pkg::DEV_CTRL_OFF, 8'h04);
        wr(uapc_pkg::PWR_OFF, 8'h08);
        rd(uapc_pkg::PWR_OFF, 8'h08);
        pn(8'ha9);
        wr(uapc_pkg::PWR_OFF, 8'h02);
        ln(4'b0100);
        rd(uapc_pkg::PWR_OFF, 8'h06);
        pn(8'h9d);
        wr(uapc_pkg::PWR_OFF, 8'h00);
        ln(4'b0000);
        pn(8'h89);
        repeat (2) @(posedge clk);
        complete_run;
    end
endmodule : uapc_top_tb_top
`default_nettype wire
